// ==== hw/adc_shadowed_config_regs.sv ====
// Purpose: Configuration register bank with shadowed staging and commit
// Assumes: Serial pins and status inputs are asynchronous to mclk
// Notes: Readback of shadowed registers returns the staged value
`default_nettype none

// Notes on behaviour
// - Writes to 0x08..0x78 only stage values
// - Writing 0x01 to 0xFF starts transfer
// - Transfer copies all staged values at once
// - Transfer flag clears itself after update
// - Port config mirrors nibbles, reset 0x18
// - Bit 5 of 0x08 picks pin role
// - Bit 0 of 0x09 enables stabilizer
// - Unmapped addresses and bits unsupported
// - Any reset loads default values
// - MSB first after power-up
module adc_shadowed_config_regs
  import adc_cfg_pkg::*;
#(
  parameter byte_type PART_ID = 8'h5a,
  parameter logic [1:0] SPEED_GRADE = 2'h0
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic serial_select_n,
  input wire logic sclk,
  input wire logic sdioIn,
  output logic sdioOut,
  output logic sdioOe,
  input wire logic powerDownPin,
  input wire logic pllLock,
  output logic full_power_down,
  output logic low_power_hold,
  output logic duty_cycle_fixer
);
  // PART_ID default is arbitrary

  reg_access_if acc();

  logic [PIN_COUNT-1:0] pinMeta;
  logic [PIN_COUNT-1:0] pinSync;
  logic softResetPending;
  logic lsbFirst;
  byte_type stagePower;
  byte_type stageClock;
  byte_type activePower;
  byte_type activeClock;
  logic commitFlag;
  logic portWrite;
  logic commitWrite;
  logic stageWrite;
  power_mode_type activeMode;

  // Two-stage synchronisers for all outside inputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      pinMeta <= SYNC_RESET;
      pinSync <= SYNC_RESET;
    end else if (ce) begin
      pinMeta <= {serial_select_n, sclk, sdioIn, powerDownPin, pllLock};
      pinSync <= pinMeta;
    end
  end

  serial_port_engine engine (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .selN(pinSync[PIN_SEL]),
    .sclk(pinSync[PIN_SCLK]),
    .sdio(pinSync[PIN_SDIO]),
    .acc(acc)
  );

  assign portWrite = acc.wrStrobe && acc.addr == ADDR_PORT;
  assign commitWrite = acc.wrStrobe && acc.addr == ADDR_COMMIT
                       && acc.wrData[COMMIT_BIT];
  assign stageWrite = acc.wrStrobe && acc.addr >= SHADOW_LO
                      && acc.addr <= SHADOW_HI;
  assign acc.lsbFirst = lsbFirst;
  assign activeMode = power_mode_type'(activePower[POWER_MODE_MSB:
                                                   POWER_MODE_LSB]);

  // Soft reset is a self-clearing request from either mirror bit
  always_ff @(posedge mclk) begin
    if (rst) begin
      softResetPending <= 1'b0;
    end else if (ce) begin
      softResetPending <= portWrite && (acc.wrData[PORT_SRST_HI]
                                        || acc.wrData[PORT_SRST_LO]);
    end
  end

  // Port configuration takes effect at once, not shadowed
  always_ff @(posedge mclk) begin
    if (rst) begin
      lsbFirst <= 1'b0;
    end else if (ce) begin
      if (softResetPending) begin
        lsbFirst <= 1'b0;
      end else if (portWrite) begin
        lsbFirst <= acc.wrData[PORT_LSB_HI]
                    || acc.wrData[PORT_LSB_LO];
      end
    end
  end

  // Staging copies; the active copy stays untouched
  always_ff @(posedge mclk) begin
    if (rst) begin
      stagePower <= POWER_RESET;
      stageClock <= CLOCK_RESET;
    end else if (ce) begin
      if (softResetPending) begin
        stagePower <= POWER_RESET;
        stageClock <= CLOCK_RESET;
      end else if (stageWrite) begin
        if (acc.addr == ADDR_POWER) begin
          stagePower <= acc.wrData & POWER_WMASK;
        end else if (acc.addr == ADDR_CLOCK) begin
          stageClock <= acc.wrData & CLOCK_WMASK;
        end
      end
    end
  end

  // Transfer flag: set wins over the self-clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      commitFlag <= 1'b0;
    end else if (ce) begin
      if (softResetPending) begin
        commitFlag <= 1'b0;
      end else if (commitWrite) begin
        commitFlag <= 1'b1;
      end else if (commitFlag) begin
        commitFlag <= 1'b0;
      end
    end
  end

  // Active copies load together from staging
  always_ff @(posedge mclk) begin
    if (rst) begin
      activePower <= POWER_RESET;
      activeClock <= CLOCK_RESET;
    end else if (ce) begin
      if (softResetPending) begin
        activePower <= POWER_RESET;
        activeClock <= CLOCK_RESET;
      end else if (commitFlag) begin
        activePower <= stagePower;
        activeClock <= stageClock;
      end
    end
  end

  // Readback decode; writes to read-only or unmapped places are dropped
  always_comb begin
    if (acc.addr == ADDR_PORT) begin
      acc.rdData = PORT_RESET;
      acc.rdData[PORT_LSB_HI] = lsbFirst;
      acc.rdData[PORT_LSB_LO] = lsbFirst;
    end else if (acc.addr == ADDR_ID) begin
      acc.rdData = PART_ID;
    end else if (acc.addr == ADDR_GRADE) begin
      acc.rdData = ZERO_BYTE;
      acc.rdData[GRADE_LSB+1:GRADE_LSB] = SPEED_GRADE;
    end else if (acc.addr == ADDR_POWER) begin
      acc.rdData = stagePower;
    end else if (acc.addr == ADDR_CLOCK) begin
      acc.rdData = stageClock;
    end else if (acc.addr == ADDR_PLL) begin
      acc.rdData = ZERO_BYTE;
      acc.rdData[PLL_LOCK_BIT] = pinSync[PIN_PLL];
    end else if (acc.addr == ADDR_COMMIT) begin
      acc.rdData = ZERO_BYTE;
      acc.rdData[COMMIT_BIT] = commitFlag;
    end else begin
      acc.rdData = ZERO_BYTE;
    end
  end

  // Operating outputs follow the active copies and the synchronised power-down pin, not staging
  always_ff @(posedge mclk) begin
    if (rst) begin
      full_power_down <= 1'b0;
      low_power_hold <= 1'b0;
      duty_cycle_fixer <= CLOCK_RESET[CLOCK_FIXER_BIT];
    end else if (ce) begin
      full_power_down <= (pinSync[PIN_PD] && !activePower[POWER_ROLE_BIT])
                         || activeMode == MODE_FULL_DOWN;
      low_power_hold <= (pinSync[PIN_PD] && activePower[POWER_ROLE_BIT])
                        || activeMode == MODE_HOLD;
      duty_cycle_fixer <= activeClock[CLOCK_FIXER_BIT];
    end
  end

  // Serial data pin
  always_ff @(posedge mclk) begin
    if (rst) begin
      sdioOut <= 1'b0;
      sdioOe <= 1'b0;
    end else if (ce) begin
      sdioOut <= acc.sdioOut;
      sdioOe <= acc.sdioOe;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence stageWriteSeq;
    ce && stageWrite && !commitFlag && !softResetPending;
  endsequence

  sequence commitSeq;
    ce && commitFlag && !softResetPending;
  endsequence

  stage_hold_a: assert property (
    stageWriteSeq |=> activePower == $past(activePower)
                      && activeClock == $past(activeClock))
    else $error("staged write changed active copy");

  commit_set_a: assert property (
    (ce && commitWrite && !softResetPending) |=> commitFlag)
    else $error("transfer write did not set flag");

  commit_copy_a: assert property (
    commitSeq |=> activePower == $past(stagePower)
                  && activeClock == $past(stageClock))
    else $error("transfer did not copy staging");

  commit_clear_a: assert property (
    (commitSeq ##1 (ce && !commitWrite)) |=> !commitFlag)
    else $error("transfer flag did not clear");

  port_mirror_a: assert property (
    (ce && portWrite && !softResetPending) |=>
      lsbFirst == ($past(acc.wrData[PORT_LSB_HI])
                   || $past(acc.wrData[PORT_LSB_LO])))
    else $error("port config bit order wrong");

  pin_role_a: assert property (
    (ce && activeMode == MODE_NORMAL && pinSync[PIN_PD]) |=>
      full_power_down == !$past(activePower[POWER_ROLE_BIT])
      && low_power_hold == $past(activePower[POWER_ROLE_BIT]))
    else $error("power pin role wrong");

  fixer_follow_a: assert property (
    ce |=> duty_cycle_fixer == $past(activeClock[CLOCK_FIXER_BIT]))
    else $error("stabilizer enable mismatch");

  unmapped_zero_a: assert property (
    (acc.addr > ADDR_GRADE && acc.addr < ADDR_POWER) |-> acc.rdData == '0)
    else $error("unmapped read not zero");

  pll_read_a: assert property (
    acc.addr == ADDR_PLL |-> acc.rdData[PLL_LOCK_BIT] == pinSync[PIN_PLL])
    else $error("lock bit readback wrong");

  id_read_a: assert property (
    acc.addr == ADDR_ID |-> acc.rdData == PART_ID)
    else $error("identifier readback wrong");

  reset_defaults_a: assert property (
    @(posedge mclk) disable iff (1'b0)
    rst |=> activePower == POWER_RESET && activeClock == CLOCK_RESET
            && stageClock == CLOCK_RESET && !commitFlag)
    else $error("defaults not loaded");

  msb_first_a: assert property (
    @(posedge mclk) disable iff (1'b0)
    rst |=> !lsbFirst && duty_cycle_fixer)
    else $error("not MSB first after reset");
endmodule

`default_nettype wire

// ==== common/adc_cfg_pkg.sv ====
// Purpose: Shared constants and types for the configuration register bank
// Assumes: Serial pins are slow next to mclk (sclk at most mclk/8)
// Notes: Addresses are 13 bits wide, data is one byte
`default_nettype none

package adc_cfg_pkg;
  localparam int ADDR_W = 13;
  localparam int INSTR_W = 16;
  localparam int CNT_W = 4;

  typedef logic [ADDR_W-1:0] addr_type;
  typedef logic [7:0] byte_type;

  // Register offsets
  localparam addr_type ADDR_PORT = 13'h000;
  localparam addr_type ADDR_ID = 13'h001;
  localparam addr_type ADDR_GRADE = 13'h002;
  localparam addr_type ADDR_POWER = 13'h008;
  localparam addr_type ADDR_CLOCK = 13'h009;
  localparam addr_type ADDR_PLL = 13'h00a;
  localparam addr_type ADDR_COMMIT = 13'h0ff;
  localparam addr_type SHADOW_LO = 13'h008;
  localparam addr_type SHADOW_HI = 13'h078;

  // Reset values
  localparam byte_type PORT_RESET = 8'h18;
  localparam byte_type POWER_RESET = 8'h00;
  localparam byte_type CLOCK_RESET = 8'h01;
  localparam byte_type ZERO_BYTE = 8'h00;

  // Writable bit masks of the shadowed registers
  localparam byte_type POWER_WMASK = 8'h23;
  localparam byte_type CLOCK_WMASK = 8'h01;

  // Field positions
  localparam int PORT_LSB_HI = 6;
  localparam int PORT_LSB_LO = 1;
  localparam int PORT_SRST_HI = 5;
  localparam int PORT_SRST_LO = 2;
  localparam int POWER_ROLE_BIT = 5;
  localparam int POWER_MODE_MSB = 1;
  localparam int POWER_MODE_LSB = 0;
  localparam int CLOCK_FIXER_BIT = 0;
  localparam int PLL_LOCK_BIT = 7;
  localparam int GRADE_LSB = 4;
  localparam int COMMIT_BIT = 0;
  localparam int INSTR_READ_BIT = 15;

  // Frame bit counts (last bit index)
  localparam logic [CNT_W-1:0] INSTR_LAST = 4'hf;
  localparam logic [CNT_W-1:0] BYTE_LAST = 4'h7;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam addr_type ADDR_ONE = 13'h001;

  // Synchroniser lane positions
  localparam int PIN_COUNT = 5;
  localparam int PIN_SEL = 4;
  localparam int PIN_SCLK = 3;
  localparam int PIN_SDIO = 2;
  localparam int PIN_PD = 1;
  localparam int PIN_PLL = 0;
  localparam logic [PIN_COUNT-1:0] SYNC_RESET = 5'h10;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_FULL_DOWN,
    MODE_HOLD,
    MODE_SPARE
  } power_mode_type;

  typedef enum logic [1:0] {
    PH_INSTR,
    PH_WRITE,
    PH_READ
  } phase_type;
endpackage

`default_nettype wire

// ==== common/reg_access_if.sv ====
// Purpose: Carrier between serial engine and register bank
// Assumes: One mclk domain
// Notes: wrStrobe is a one-cycle pulse; rdData follows addr
`default_nettype none

interface reg_access_if;
  import adc_cfg_pkg::*;
  logic wrStrobe;
  addr_type addr;
  byte_type wrData;
  byte_type rdData;
  logic lsbFirst;
  logic sdioOut;
  logic sdioOe;

  modport engine(
    output wrStrobe,
    output addr,
    output wrData,
    output sdioOut,
    output sdioOe,
    input rdData,
    input lsbFirst
  );
  modport bank(
    input wrStrobe,
    input addr,
    input wrData,
    input sdioOut,
    input sdioOe,
    output rdData,
    output lsbFirst
  );
endinterface

`default_nettype wire

// ==== hw/serial_port_engine.sv ====
// Purpose: Serial frame engine: instruction, write bytes, readback bytes
// Assumes: Inputs already synchronised to mclk
// Notes: Address steps down in MSB-first mode and up in LSB-first mode
`default_nettype none

module serial_port_engine
  import adc_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic selN,
  input wire logic sclk,
  input wire logic sdio,
  reg_access_if.engine acc
);
  logic sclkLast;
  logic [INSTR_W-1:0] shiftIn;
  logic [INSTR_W-1:0] next_shift;
  byte_type next_byte;
  logic [CNT_W-1:0] bitCnt;
  phase_type phase;
  byte_type outBuf;
  logic loadOut;
  logic rise;
  logic fall;

  assign rise = sclk & ~sclkLast;
  assign fall = ~sclk & sclkLast;

  // Bit order follows the port configuration
  always_comb begin
    if (acc.lsbFirst) begin
      next_shift = {sdio, shiftIn[INSTR_W-1:1]};
      next_byte = next_shift[INSTR_W-1:INSTR_W-8];
    end else begin
      next_shift = {shiftIn[INSTR_W-2:0], sdio};
      next_byte = next_shift[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sclkLast <= 1'b0;
    end else if (ce) begin
      sclkLast <= sclk;
    end
  end

  // Frame sequencing
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase <= PH_INSTR;
      bitCnt <= CNT_ZERO;
      shiftIn <= '0;
      acc.addr <= '0;
      acc.wrData <= ZERO_BYTE;
      acc.wrStrobe <= 1'b0;
      loadOut <= 1'b0;
    end else if (ce) begin
      acc.wrStrobe <= 1'b0;
      loadOut <= 1'b0;
      if (acc.wrStrobe) begin
        acc.addr <= acc.lsbFirst ? acc.addr + ADDR_ONE : acc.addr - ADDR_ONE;
      end
      if (selN) begin
        phase <= PH_INSTR;
        bitCnt <= CNT_ZERO;
      end else if (rise) begin
        shiftIn <= next_shift;
        bitCnt <= CNT_W'(bitCnt + CNT_ONE);
        case (phase)
          PH_INSTR: begin
            if (bitCnt == INSTR_LAST) begin
              acc.addr <= next_shift[ADDR_W-1:0];
              bitCnt <= CNT_ZERO;
              loadOut <= next_shift[INSTR_READ_BIT];
              phase <= next_shift[INSTR_READ_BIT] ? PH_READ : PH_WRITE;
            end
          end
          PH_WRITE: begin
            if (bitCnt == BYTE_LAST) begin
              acc.wrData <= next_byte;
              acc.wrStrobe <= 1'b1;
              bitCnt <= CNT_ZERO;
            end
          end
          default: begin
            if (bitCnt == BYTE_LAST) begin
              bitCnt <= CNT_ZERO;
              loadOut <= 1'b1;
              acc.addr <= acc.lsbFirst ? acc.addr + ADDR_ONE
                                       : acc.addr - ADDR_ONE;
            end
          end
        endcase
      end
    end
  end

  // Readback shifter, driven on falling sclk
  always_ff @(posedge mclk) begin
    if (rst) begin
      outBuf <= ZERO_BYTE;
      acc.sdioOut <= 1'b0;
      acc.sdioOe <= 1'b0;
    end else if (ce) begin
      if (selN) begin
        acc.sdioOut <= 1'b0;
        acc.sdioOe <= 1'b0;
      end else if (loadOut) begin
        outBuf <= acc.rdData;
      end else if (fall && phase == PH_READ) begin
        acc.sdioOe <= 1'b1;
        if (acc.lsbFirst) begin
          acc.sdioOut <= outBuf[0];
          outBuf <= {1'b0, outBuf[7:1]};
        end else begin
          acc.sdioOut <= outBuf[7];
          outBuf <= {outBuf[6:0], 1'b0};
        end
      end
    end
  end
endmodule

`default_nettype wire

// ==== tb/spi_host_model.sv ====
// Purpose: Serial port host that frames register reads and writes
// Assumes: Each sclk half lasts HALF mclk cycles
// Notes: A released data line shows the inverse of the last bit driven
`default_nettype none

module spi_host_model
  import adc_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic dutOut,
  input wire logic dutOe,
  output logic selN,
  output logic sclk,
  output logic sdioLine
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 10;
  logic drv = 1'b0;
  logic hostOe = 1'b0;
  logic lsb = 1'b0;

  initial begin
    selN = 1'b1;
    sclk = 1'b0;
  end

  assign sdioLine = dutOe ? dutOut : (hostOe ? drv : ~drv);

  task automatic wait_mclk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Bit order follows lsb for instruction and data alike
  task automatic xfer(input logic rd, input addr_type a,
                      input byte_type wd, output byte_type rdv);
    logic [15:0] ins;
    ins = {rd, 2'b00, a};
    rdv = 8'h00;
    wait_mclk(1);
    selN = 1'b0;
    hostOe = 1'b1;
    for (int i = 0; i < 24; i++) begin
      sclk = 1'b0;
      if (i < 16) drv = ins[lsb ? i : 15 - i];
      else if (!rd) drv = wd[lsb ? i - 16 : 23 - i];
      else hostOe = 1'b0;
      wait_mclk(HALF);
      if (rd && i >= 16) rdv[lsb ? i - 16 : 23 - i] = sdioLine;
      sclk = 1'b1;
      wait_mclk(HALF);
    end
    hostOe = 1'b0;
    selN = 1'b1;
    sclk = 1'b0;
    wait_mclk(2 * HALF);
  endtask
endmodule

`default_nettype wire

// ==== tb/tb_adc_shadowed_config_regs.sv ====
// Purpose: Self-checking bench for the shadowed configuration bank
// Assumes: Host model frames every register access
// Notes: PART_ID value here is arbitrary
`default_nettype none

module tb_adc_shadowed_config_regs
  import adc_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic pdPin = 1'b0;
  logic pllLock = 1'b0;
  wire logic selN, sclk, sdioLine, sdioOut, sdioOe, fpd, lph, dcf;
  int mismatches = 0;
  int samples_checked = 0;
  byte_type rv;

  spi_host_model host(.mclk(mclk), .dutOut(sdioOut), .dutOe(sdioOe),
    .selN(selN), .sclk(sclk), .sdioLine(sdioLine));

  adc_shadowed_config_regs #(.PART_ID(8'h3c), .SPEED_GRADE(2'h1)) dut(
    .mclk(mclk), .rst(rst), .ce(ce), .serial_select_n(selN),
    .sclk(sclk), .sdioIn(sdioLine), .sdioOut(sdioOut), .sdioOe(sdioOe),
    .powerDownPin(pdPin), .pllLock(pllLock), .full_power_down(fpd),
    .low_power_hold(lph), .duty_cycle_fixer(dcf));

  initial begin
    forever #2 mclk = ~mclk;
  end

  task automatic check(input byte_type seen, input byte_type exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input addr_type a, input byte_type d);
    host.xfer(1'b0, a, d, rv);
  endtask

  task automatic rd(input addr_type a);
    host.xfer(1'b1, a, 8'h00, rv);
  endtask

  task automatic outs(input logic f, input logic l, input logic d);
    check({5'h00, fpd, lph, dcf}, {5'h00, f, l, d});
  endtask

  task automatic commit;
    wr(ADDR_COMMIT, 8'h01);
    cyc(10);
  endtask

  task automatic test_defaults;
    outs(1'b0, 1'b0, 1'b1);
    rd(ADDR_PORT);
    check(rv, 8'h18);
    rd(ADDR_POWER);
    check(rv, 8'h00);
    rd(ADDR_CLOCK);
    check(rv, 8'h01);
    rd(ADDR_COMMIT);
    check(rv, 8'h00);
  endtask

  task automatic test_shadow;
    int n;
    wr(ADDR_POWER, 8'h01);
    wr(ADDR_CLOCK, 8'h00);
    cyc(10);
    outs(1'b0, 1'b0, 1'b1);
    rd(ADDR_POWER);
    check(rv, 8'h01);
    wr(ADDR_COMMIT, 8'h01);
    n = 0;
    while (fpd !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    check({7'h00, dcf}, 8'h00);
    outs(1'b1, 1'b0, 1'b0);
    rd(ADDR_COMMIT);
    check(rv, 8'h00);
  endtask

  task automatic test_pin_role;
    wr(ADDR_POWER, 8'h00);
    commit();
    pdPin = 1'b1;
    cyc(6);
    outs(1'b1, 1'b0, 1'b0);
    wr(ADDR_POWER, 8'h20);
    cyc(6);
    outs(1'b1, 1'b0, 1'b0);
    commit();
    outs(1'b0, 1'b1, 1'b0);
    pdPin = 1'b0;
    cyc(6);
    outs(1'b0, 1'b0, 1'b0);
  endtask

  task automatic test_read_only;
    wr(ADDR_ID, 8'hff);
    rd(ADDR_ID);
    check(rv, 8'h3c);
    wr(ADDR_GRADE, 8'hff);
    rd(ADDR_GRADE);
    check(rv, 8'h10);
    pllLock = 1'b1;
    cyc(6);
    wr(ADDR_PLL, 8'h00);
    rd(ADDR_PLL);
    check(rv, 8'h80);
    pllLock = 1'b0;
    cyc(6);
    rd(ADDR_PLL);
    check(rv, 8'h00);
    wr(13'h013, 8'hff);
    rd(13'h013);
    check(rv, 8'h00);
  endtask

  task automatic test_bit_order;
    wr(ADDR_PORT, 8'h42);
    host.lsb = 1'b1;
    rd(ADDR_PORT);
    check(rv, 8'h5a);
    wr(ADDR_PORT, 8'h24);
    host.lsb = 1'b0;
    cyc(6);
    outs(1'b0, 1'b0, 1'b1);
    rd(ADDR_PORT);
    check(rv, 8'h18);
    rd(ADDR_POWER);
    check(rv, 8'h00);
  endtask

  task automatic test_reset_enable;
    wr(ADDR_PORT, 8'h42);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(4);
    rd(ADDR_PORT);
    check(rv, 8'h18);
    ce = 1'b0;
    pdPin = 1'b1;
    cyc(6);
    outs(1'b0, 1'b0, 1'b1);
    ce = 1'b1;
    cyc(6);
    outs(1'b1, 1'b0, 1'b1);
    pdPin = 1'b0;
    cyc(6);
    outs(1'b0, 1'b0, 1'b1);
  endtask

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #120000;
    mismatches++;
    complete_run();
  end

  initial begin
    cyc(4);
    rst = 1'b0;
    cyc(4);
    test_defaults();
    test_shadow();
    test_pin_role();
    test_read_only();
    test_bit_order();
    test_reset_enable();
    complete_run();
  end
endmodule

`default_nettype wire
